// ==== hdl/cmm_map.svh ====
// Purpose: Constants for the code memory map decoder.
// Assumes: 50 MHz core clock; 16-bit code addresses.
`ifndef CMM_MAP_SVH
`define CMM_MAP_SVH
`define CMM_ADDR_W      16
`define CMM_BLK_MSB     15
`define CMM_BLK_LSB     12
`define CMM_SEG_W       12
`define CMM_BLK0_RESET  4'h0
`define CMM_BLK1_RESET  4'h1
`define CMM_LOW_BLK     4'h0
`define CMM_XA_RESET    16'h0000
`define CMM_RD_RESET    8'h00
`define CMM_PC_RESET    16'h0000
`define CMM_ASM_RESET   16'h0000
`define CMM_VEC_RESET   16'h0000
`define CMM_VEC_EXT0    16'h0003
`define CMM_VEC_TIM0    16'h000b
`define CMM_VEC_EXT1    16'h0013
`define CMM_VEC_TIM1    16'h001b
`define CMM_VEC_SER     16'h0023
`endif

// ==== hdl/cmm_pkg.sv ====
// Purpose: Types for the code memory map decoder.
// Assumes: Constants come from cmm_map.svh.
// Notes: None.
`include "cmm_map.svh"
package cmm_pkg;
  typedef logic [`CMM_ADDR_W-1:0] cmm_addr_t;
  typedef logic [3:0]             cmm_blk_t;
  typedef enum logic [2:0] {
    CMM_VEC_RST  = 3'h0,
    CMM_VEC_X0   = 3'h1,
    CMM_VEC_T0   = 3'h2,
    CMM_VEC_X1   = 3'h3,
    CMM_VEC_T1   = 3'h4,
    CMM_VEC_SP   = 3'h5
  } cmm_vec_t;
  typedef enum logic [2:0] {
    CMM_IDLE  = 3'b001,
    CMM_FETCH = 3'b010,
    CMM_EXT   = 3'b100
  } cmm_state_t;
endpackage : cmm_pkg

// ==== hdl/cmm_seg_if.sv ====
// Purpose: Port bundle between decoder and segment RAM.
// Assumes: One access per cycle.
// Notes: Read data arrive one cycle after the request.
`timescale 1ns/1ns
interface cmm_seg_if;
  logic        we;
  logic        sel;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport ctrl (output we, output sel, output addr, output wdata,
                input rdata);
  modport mem  (input we, input sel, input addr, input wdata,
                output rdata);
endinterface : cmm_seg_if

// ==== hdl/cmm_seg_ram.sv ====
// Purpose: Two 4K byte emulator segments in one memory.
// Assumes: Synchronous read, registered data out.
// Notes: Address bit 12 picks the segment.
`timescale 1ns/1ns
module cmm_seg_ram #(
  parameter int DEPTH = 8192
) (
  input  wire logic core_clk,
  cmm_seg_if.mem    seg
);
  initial begin
    if (DEPTH != 8192) $error("Segment memory must hold two 4K segments.");
  end
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_q;
  always_ff @(posedge core_clk) begin
    if (seg.sel && seg.we) begin
      mem[seg.addr] <= seg.wdata;
    end
    rdata_q <= mem[seg.addr];
  end
  assign seg.rdata = rdata_q;
endmodule : cmm_seg_ram

// ==== hdl/cmm_decoder.sv ====
// Purpose: Decode code addresses onto emulator segments or user memory.
// Assumes: Inputs synchronous to core_clk.
// Notes: Host commands are one-cycle strobes.
`timescale 1ns/1ns
`include "cmm_map.svh"
module cmm_decoder (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            reset_command,
  input  wire logic            map_write,
  input  wire logic            map_all_user,
  input  wire cmm_pkg::cmm_blk_t map_blk0,
  input  wire cmm_pkg::cmm_blk_t map_blk1,
  input  wire logic            pc_load,
  input  wire cmm_pkg::cmm_addr_t pc_value,
  input  wire logic            pc_advance,
  input  wire logic            vector_take,
  input  wire cmm_pkg::cmm_vec_t vector_sel,
  input  wire logic            fetch_req,
  input  wire cmm_pkg::cmm_addr_t fetch_addr,
  input  wire logic            code_byte_access,
  input  wire logic            code_write,
  input  wire cmm_pkg::cmm_addr_t code_addr,
  input  wire logic [7:0]      code_wdata,
  input  wire logic            asm_org,
  input  wire cmm_pkg::cmm_addr_t asm_org_addr,
  input  wire logic            inline_assembly_command,
  input  wire logic [1:0]      asm_len,
  input  wire logic [7:0]      asm_byte,
  input  wire logic            external_access_n,
  input  wire logic [7:0]      ext_rdata,
  output cmm_pkg::cmm_addr_t   program_counter,
  output cmm_pkg::cmm_addr_t   asm_pointer,
  output cmm_pkg::cmm_blk_t    seg_blk0,
  output cmm_pkg::cmm_blk_t    seg_blk1,
  output logic                 all_user,
  output cmm_pkg::cmm_addr_t   ext_addr,
  output logic                 addr_latch_strobe,
  output logic                 program_fetch_strobe_n,
  output logic                 on_chip_hit,
  output logic [7:0]           rdata,
  output logic                 rdata_valid,
  output logic                 write_refused
);
  import cmm_pkg::*;

  function automatic logic [1:0] seg_hit(cmm_addr_t a, cmm_blk_t b0,
                                         cmm_blk_t b1, logic usr);
    seg_hit[0] = !usr && (a[`CMM_BLK_MSB:`CMM_BLK_LSB] == b0);
    seg_hit[1] = !usr && (a[`CMM_BLK_MSB:`CMM_BLK_LSB] == b1);
  endfunction : seg_hit

  function automatic cmm_addr_t vec_addr(cmm_vec_t v);
    case (v)
      CMM_VEC_RST: vec_addr = `CMM_VEC_RESET;
      CMM_VEC_X0:  vec_addr = `CMM_VEC_EXT0;
      CMM_VEC_T0:  vec_addr = `CMM_VEC_TIM0;
      CMM_VEC_X1:  vec_addr = `CMM_VEC_EXT1;
      CMM_VEC_T1:  vec_addr = `CMM_VEC_TIM1;
      CMM_VEC_SP:  vec_addr = `CMM_VEC_SER;
      default:     vec_addr = `CMM_VEC_RESET;
    endcase
  endfunction : vec_addr

  typedef struct packed {
    cmm_state_t st;
    cmm_addr_t  pc;
    cmm_addr_t  ap;
    cmm_blk_t   b0;
    cmm_blk_t   b1;
    logic       usr;
    cmm_addr_t  xa;
    logic       ale;
    logic       program_fetch_strobe_n_n;
    logic       onchip;
    logic [7:0] rd;
    logic       rv;
    logic       wref;
  } cmm_regs_t;

  cmm_regs_t  r;
  cmm_regs_t  next_r;
  cmm_seg_if  seg ();
  logic [1:0] fhit;
  logic [1:0] whit;
  logic [1:0] ahit;
  logic       low_blk;
  logic       ext_fetch;

  cmm_seg_ram #(.DEPTH(8192)) u_ram (.core_clk(core_clk), .seg(seg));

  // The block number must be the top address bits, just above the offset.
  if (`CMM_BLK_MSB != `CMM_ADDR_W - 1 || `CMM_BLK_LSB != `CMM_SEG_W ||
      `CMM_ADDR_W - `CMM_SEG_W != $bits(cmm_blk_t)) begin : g_bad_map
    $error("Block field does not match the code address layout.");
  end

  always_comb begin
    fhit    = seg_hit(fetch_addr, r.b0, r.b1, r.usr);
    whit    = seg_hit(code_addr, r.b0, r.b1, r.usr);
    ahit    = seg_hit(r.ap, r.b0, r.b1, r.usr);
    low_blk = (fetch_addr[`CMM_BLK_MSB:`CMM_BLK_LSB] == `CMM_LOW_BLK);
    // An active access pin sends the lowest block to user memory.
    ext_fetch = fetch_req && ((fhit == 2'b00) ||
                              (low_blk && !external_access_n));
  end

  always_comb begin
    next_r        = r;
    next_r.ale    = 1'b0;
    next_r.program_fetch_strobe_n_n = 1'b1;
    next_r.rv     = 1'b0;
    next_r.wref   = 1'b0;
    seg.we        = 1'b0;
    seg.sel       = 1'b0;
    seg.addr      = {1'b0, fetch_addr[`CMM_SEG_W-1:0]};
    seg.wdata     = code_wdata;
    if (reset_command) begin
      next_r.b0  = `CMM_BLK0_RESET;
      next_r.b1  = `CMM_BLK1_RESET;
      next_r.usr = 1'b0;
      next_r.ap  = `CMM_ASM_RESET;
    end else if (map_write) begin
      // Equal blocks are refused unless all-user is written, so the two segments stay distinct.
      if (map_all_user || map_blk0 != map_blk1) begin
        next_r.usr = map_all_user;
        next_r.b0  = map_blk0;
        next_r.b1  = map_blk1;
      end
    end
    if (pc_load) begin
      next_r.pc = pc_value;
    end else if (vector_take) begin
      next_r.pc = vec_addr(vector_sel);
    end else if (pc_advance) begin
      next_r.pc = r.pc + 16'h0001;
    end
    if (asm_org) begin
      next_r.ap = asm_org_addr;
    end
    case (r.st)
      CMM_IDLE: begin
        if (inline_assembly_command) begin
          if (ahit != 2'b00) begin
            seg.sel   = 1'b1;
            seg.we    = 1'b1;
            seg.addr  = {ahit[1], r.ap[`CMM_SEG_W-1:0]};
            seg.wdata = asm_byte;
            next_r.ap = r.ap + {14'h0000, asm_len};
          end else begin
            next_r.wref = 1'b1;
          end
        end else if (code_byte_access && code_write) begin
          if (whit != 2'b00) begin
            seg.sel  = 1'b1;
            seg.we   = 1'b1;
            seg.addr = {whit[1], code_addr[`CMM_SEG_W-1:0]};
          end else begin
            next_r.wref = 1'b1;
          end
        end else if (fetch_req) begin
          next_r.onchip = low_blk && external_access_n;
          if (ext_fetch) begin
            next_r.xa     = fetch_addr;
            next_r.ale    = 1'b1;
            next_r.st     = CMM_EXT;
          end else begin
            seg.sel   = 1'b1;
            seg.addr  = {fhit[1], fetch_addr[`CMM_SEG_W-1:0]};
            next_r.st = CMM_FETCH;
          end
        end
      end
      CMM_FETCH: begin
        next_r.rd = seg.rdata;
        next_r.rv = 1'b1;
        next_r.st = CMM_IDLE;
      end
      CMM_EXT: begin
        if (r.program_fetch_strobe_n_n) begin
          next_r.program_fetch_strobe_n_n = 1'b0;
        end else begin
          // User memory drives the bus only while the fetch strobe is low.
          // Absent user memory just returns whatever the bus shows.
          next_r.rd = ext_rdata;
          next_r.rv = 1'b1;
          next_r.st = CMM_IDLE;
        end
      end
      default: next_r.st = CMM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st:     CMM_IDLE,
             pc:     `CMM_PC_RESET,
             ap:     `CMM_ASM_RESET,
             b0:     `CMM_BLK0_RESET,
             b1:     `CMM_BLK1_RESET,
             usr:    1'b0,
             xa:     `CMM_XA_RESET,
             ale:    1'b0,
             program_fetch_strobe_n_n: 1'b1,
             onchip: 1'b0,
             rd:     `CMM_RD_RESET,
             rv:     1'b0,
             wref:   1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign program_counter        = r.pc;
  assign asm_pointer            = r.ap;
  assign seg_blk0               = r.b0;
  assign seg_blk1               = r.b1;
  assign all_user               = r.usr;
  assign ext_addr               = r.xa;
  assign addr_latch_strobe      = r.ale;
  assign program_fetch_strobe_n = r.program_fetch_strobe_n_n;
  assign on_chip_hit            = r.onchip;
  assign rdata                  = r.rd;
  assign rdata_valid            = r.rv;
  assign write_refused          = r.wref;
endmodule : cmm_decoder

// ==== tb/cmm_user_board.sv ====
// Purpose: User board model with external code memory.
// Assumes: Memory present over the whole external space.
// Notes: Data bus shows noise outside fetch strobes.
`timescale 1ns/1ns
module cmm_user_board (
  input  wire cmm_pkg::cmm_addr_t ext_addr,
  input  wire logic               addr_latch_strobe,
  input  wire logic               program_fetch_strobe_n,
  input  wire cmm_pkg::cmm_blk_t  seg_blk0,
  input  wire cmm_pkg::cmm_blk_t  seg_blk1,
  input  wire logic               all_user,
  output logic [7:0]              ext_rdata,
  output logic                    external_access_n
);
  import cmm_pkg::*;
  logic [7:0] pattern;
  // Content is a fixed function of the address, low block included.
  assign pattern = ext_addr[7:0] ^ ext_addr[15:8] ^ 8'h5a;
  // Only the fetch strobe opens the memory; the latch strobe shows the
  // low address byte and an idle bus shows the inverse of the content.
  assign ext_rdata = !program_fetch_strobe_n ? pattern :
                     addr_latch_strobe ? ext_addr[7:0] : ~pattern;
  // Pin is high only while a segment sits on the lowest block.
  assign external_access_n = !all_user &&
                             (seg_blk0 == 4'h0 || seg_blk1 == 4'h0);
endmodule : cmm_user_board

// ==== tb/cmm_decoder_monitor.sv ====
// Purpose: Port checks for the code map decoder.
// Assumes: One clock domain.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ns
`include "cmm_map.svh"
module cmm_decoder_monitor (
  input wire logic               core_clk,
  input wire logic               reset_n,
  input wire logic               reset_command,
  input wire logic               pc_load,
  input wire cmm_pkg::cmm_addr_t pc_value,
  input wire logic               pc_advance,
  input wire logic               vector_take,
  input wire cmm_pkg::cmm_vec_t  vector_sel,
  input wire cmm_pkg::cmm_addr_t program_counter,
  input wire cmm_pkg::cmm_blk_t  seg_blk0,
  input wire cmm_pkg::cmm_blk_t  seg_blk1,
  input wire logic               all_user,
  input wire cmm_pkg::cmm_addr_t ext_addr,
  input wire logic               addr_latch_strobe,
  input wire logic               program_fetch_strobe_n,
  input wire logic               rdata_valid
);
  import cmm_pkg::*;
  localparam cmm_addr_t vec_tab [6] = '{`CMM_VEC_RESET, `CMM_VEC_EXT0,
    `CMM_VEC_TIM0, `CMM_VEC_EXT1, `CMM_VEC_TIM1, `CMM_VEC_SER};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_reset_map: assert property (reset_command |=>
    seg_blk0 == 4'h0 && seg_blk1 == 4'h1 && !all_user) else $error("map");
  a_pc_load: assert property (pc_load |=>
    program_counter == $past(pc_value)) else $error("pc load");
  a_vector_pc: assert property (vector_take && !pc_load |=>
    program_counter == vec_tab[$past(vector_sel)]) else $error("vector");
  a_pc_step: assert property (
    pc_advance && !pc_load && !vector_take |=>
    program_counter == $past(program_counter) + 16'h1) else $error("step");
  a_ale_fetch: assert property (addr_latch_strobe |=>
    (!program_fetch_strobe_n && !rdata_valid) ##1
    (program_fetch_strobe_n && rdata_valid)) else $error("fetch strobe");
  a_ale_pulse: assert property (addr_latch_strobe |=>
    !addr_latch_strobe) else $error("ale pulse");
  a_strobe_order: assert property ($fell(program_fetch_strobe_n) |->
    $past(addr_latch_strobe)) else $error("strobe order");
  a_ext_unmapped: assert property (
    addr_latch_strobe |-> all_user ||
    (ext_addr[15:12] != seg_blk0 && ext_addr[15:12] != seg_blk1))
    else $error("mapped address went external");
  a_map_distinct: assert property (!all_user |->
    seg_blk0 != seg_blk1) else $error("segments overlap");
endmodule : cmm_decoder_monitor
bind cmm_decoder cmm_decoder_monitor i_cmm_decoder_monitor (.core_clk,
  .reset_n, .reset_command, .pc_load, .pc_value, .pc_advance, .vector_take,
  .vector_sel, .program_counter, .seg_blk0, .seg_blk1, .all_user, .ext_addr,
  .addr_latch_strobe, .program_fetch_strobe_n, .rdata_valid);

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the code map decoder.
// Assumes: Inputs change on the falling clock edge.
// Notes: Map rows first, then reset, pointer and counter cases.
`timescale 1ns/1ns
`include "cmm_map.svh"
module tb_top;
  import cmm_pkg::*;
  typedef struct {cmm_blk_t b0; cmm_blk_t b1; logic u; cmm_addr_t a;
                  logic ext;} cmm_row_t;
  logic core_clk = 0, reset_n = 0, reset_command = 0, map_write = 0;
  logic map_all_user = 0, pc_load = 0, pc_advance = 0, vector_take = 0;
  logic fetch_req = 0, code_byte_access = 0, code_write = 0, asm_org = 0;
  logic inline_assembly_command = 0, external_access_n, addr_latch_strobe;
  logic program_fetch_strobe_n, all_user, on_chip_hit, rdata_valid;
  logic write_refused;
  logic [1:0] asm_len = 2'h2;
  logic [7:0] code_wdata = 8'h00, asm_byte = 8'h96, ext_rdata, rdata;
  cmm_blk_t map_blk0 = 4'h0, map_blk1 = 4'h1, seg_blk0, seg_blk1;
  cmm_vec_t vector_sel = CMM_VEC_RST;
  cmm_addr_t pc_value = 16'h0, fetch_addr = 16'h0, code_addr = 16'h0;
  cmm_addr_t asm_org_addr = 16'h0, program_counter, asm_pointer, ext_addr;
  int num_errors = 0, checks = 0, cycles = 0;
  cmm_addr_t vec_tab [6] = '{`CMM_VEC_RESET, `CMM_VEC_EXT0, `CMM_VEC_TIM0,
                             `CMM_VEC_EXT1, `CMM_VEC_TIM1, `CMM_VEC_SER};
  cmm_row_t rows [8] = '{'{4'h0, 4'h1, 1'b0, 16'h0000, 1'b0},
    '{4'h0, 4'h1, 1'b0, 16'h1ffe, 1'b0}, '{4'h0, 4'h1, 1'b0, 16'h2000, 1'b1},
    '{4'h0, 4'h5, 1'b0, 16'h1000, 1'b1}, '{4'h0, 4'h5, 1'b0, 16'h5abc, 1'b0},
    '{4'h5, 4'h6, 1'b0, 16'h0010, 1'b1}, '{4'h2, 4'h3, 1'b1, 16'h2345, 1'b1},
    '{4'he, 4'hf, 1'b0, 16'hffff, 1'b0}};
  cmm_decoder i_cmm_decoder (.core_clk, .reset_n, .reset_command, .map_write,
    .map_all_user, .map_blk0, .map_blk1, .pc_load, .pc_value, .pc_advance,
    .vector_take, .vector_sel, .fetch_req, .fetch_addr, .code_byte_access,
    .code_write, .code_addr, .code_wdata, .asm_org, .asm_org_addr,
    .inline_assembly_command, .asm_len, .asm_byte, .external_access_n,
    .ext_rdata, .program_counter, .asm_pointer, .seg_blk0, .seg_blk1,
    .all_user, .ext_addr, .addr_latch_strobe, .program_fetch_strobe_n,
    .on_chip_hit, .rdata, .rdata_valid, .write_refused);
  cmm_user_board i_cmm_user_board (.ext_addr, .addr_latch_strobe,
    .program_fetch_strobe_n, .seg_blk0, .seg_blk1, .all_user, .ext_rdata,
    .external_access_n);
  always #10 core_clk = ~core_clk;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick();
    @(negedge core_clk);
  endtask : tick
  task automatic chk_home();
    chk("blk0", 4'h0, seg_blk0);
    chk("blk1", 4'h1, seg_blk1);
    chk("user", 1'b0, all_user);
    chk("asm", 16'h0000, asm_pointer);
    chk("strobe", 1'b1, program_fetch_strobe_n & !addr_latch_strobe);
  endtask : chk_home
  task automatic set_map(input cmm_blk_t b0, b1, input logic u);
    map_blk0 = b0;
    map_blk1 = b1;
    map_all_user = u;
    map_write = 1'b1;
    tick();
    map_write = 1'b0;
  endtask : set_map
  task automatic fetch(input cmm_addr_t a, input logic ext, logic [7:0] d);
    fetch_addr = a;
    fetch_req = 1'b1;
    tick();
    fetch_req = 1'b0;
    chk("ale", ext, addr_latch_strobe);
    tick();
    chk("fetch_n", !ext, program_fetch_strobe_n);
    if (ext) begin
      chk("early", 1'b0, rdata_valid);
      chk("xaddr", a, ext_addr);
      tick();
    end
    chk("valid", 1'b1, rdata_valid);
    chk("fetch_end", 1'b1, program_fetch_strobe_n);
    chk("rdata", d, rdata);
    tick();
    chk("hit", a[15:12] == 4'h0 && !ext, on_chip_hit);
  endtask : fetch
  initial begin
    logic [7:0] d;
    repeat (5) tick();
    chk_home();
    chk("pc", 16'h0000, program_counter);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      set_map(rows[i].b0, rows[i].b1, rows[i].u);
      chk("map", rows[i].b1, seg_blk1);
      chk("user", rows[i].u, all_user);
      code_addr = rows[i].a;
      code_wdata = rows[i].a[7:0] ^ 8'hc3;
      code_byte_access = 1'b1;
      code_write = 1'b1;
      tick();
      code_byte_access = 1'b0;
      code_write = 1'b0;
      chk("refused", rows[i].ext, write_refused);
      chk("wr_ale", 1'b0, addr_latch_strobe);
      d = rows[i].ext ? rows[i].a[7:0] ^ rows[i].a[15:8] ^ 8'h5a : code_wdata;
      fetch(rows[i].a, rows[i].ext, d);
    end
    set_map(4'h7, 4'h7, 1'b0);
    chk("same", 4'he, seg_blk0);
    reset_command = 1'b1;
    tick();
    reset_command = 1'b0;
    chk_home();
    asm_org_addr = 16'h1ffe;
    asm_org = 1'b1;
    tick();
    asm_org = 1'b0;
    inline_assembly_command = 1'b1;
    tick();
    inline_assembly_command = 1'b0;
    chk("asm_ptr", 16'h2000, asm_pointer);
    tick();
    fetch(16'h1ffe, 1'b0, 8'h96);
    inline_assembly_command = 1'b1;
    tick();
    inline_assembly_command = 1'b0;
    chk("asm_refused", 1'b1, write_refused);
    chk("asm_hold", 16'h2000, asm_pointer);
    pc_value = 16'hbeef;
    pc_load = 1'b1;
    vector_take = 1'b1;
    pc_advance = 1'b1;
    tick();
    pc_load = 1'b0;
    vector_take = 1'b0;
    chk("pc_load", 16'hbeef, program_counter);
    tick();
    chk("pc_step", 16'hbef0, program_counter);
    pc_advance = 1'b0;
    vector_take = 1'b1;
    for (int v = 5; v >= 0; v--) begin
      vector_sel = cmm_vec_t'(v);
      tick();
      chk("vector", vec_tab[v], program_counter);
    end
    vector_take = 1'b0;
    set_map(4'h9, 4'ha, 1'b0);
    reset_n = 1'b0;
    #5;
    chk_home();
    tick();
    reset_n = 1'b1;
    tick();
    chk_home();
    tick();
    chk_home();
    report_and_stop();
  end
endmodule : tb_top
